// *** updown_counter_pkg.sv ***
// Purpose: shared constants and types for the up/down encoder counter channel
// Assumes: 25 MHz system clock, AHB-Lite word registers
// Notes:   control word is carried as a packed struct
package updown_counter_pkg;

    localparam int          CLK_NS        = 40;
    localparam int          OUT_PULSE_NS  = 1000;
    localparam int          OUT_PULSE_CYC = (OUT_PULSE_NS + CLK_NS - 1) / CLK_NS;

    localparam logic [7:0]  ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  ADDR_CMD      = 8'h04;
    localparam logic [7:0]  ADDR_ZCOUNT   = 8'h08;
    localparam logic [7:0]  ADDR_PRESET   = 8'h0C;
    localparam logic [7:0]  ADDR_CMP0     = 8'h10;
    localparam logic [7:0]  ADDR_CMP1     = 8'h14;
    localparam logic [7:0]  ADDR_COUNT    = 8'h18;
    localparam logic [7:0]  ADDR_STATUS   = 8'h1C;
    localparam logic [7:0]  ADDR_SAMPLE   = 8'h20;

    localparam int          CMD_START     = 0;
    localparam int          CMD_STOP      = 1;
    localparam int          CMD_START_ALL = 2;
    localparam int          CMD_STOP_ALL  = 3;
    localparam int          CMD_PRESET    = 4;
    localparam int          CMD_PRE_ALL   = 5;
    localparam int          CMD_CLEAR     = 6;
    localparam int          CMD_SAMP_GO   = 7;
    localparam int          CMD_SAMP_END  = 8;

    localparam int          IN_A          = 0;
    localparam int          IN_B          = 1;
    localparam int          IN_Z          = 2;
    localparam int          IN_CTL        = 3;
    localparam int          IN_XCLK       = 4;
    localparam int          IN_XSTART     = 5;
    localparam int          IN_XSTOP      = 6;
    localparam int          IN_W          = 7;

    localparam logic [15:0] ZCLR_RESET    = 16'h0001;
    localparam logic [15:0] ZCLR_UNLIM    = 16'hFFFF;
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;

    typedef enum logic [1:0] {MODE_2PH_SYNC, MODE_2PH_ASYNC, MODE_SINGLE, MODE_GATED} count_mode_t;
    typedef enum logic [1:0] {MULT_X1, MULT_X2, MULT_X4, MULT_RSVD} mult_t;
    typedef enum logic [1:0] {FUNC_GPIN, FUNC_STARTSTOP, FUNC_PRESET, FUNC_CLEAR} ctl_func_t;

    typedef struct packed {
        logic [13:0] pad;
        logic        samp_stop_fall;
        logic        samp_start_fall;
        logic        samp_link;
        logic        out_pol;
        logic        out_pulse;
        logic        out_level;
        logic        pre_m1;
        logic        pre_m0;
        logic        ctl_stop_fall;
        logic        ctl_start_fall;
        ctl_func_t   ctl_func;
        logic        z_neg;
        logic        cw_dec;
        mult_t       mult;
        count_mode_t mode;
    } ctrl_t;

endpackage

// *** sync_edge.sv ***
// Purpose: two-flop synchroniser with edge detection for a group of pins
// Assumes: inputs asynchronous to i_clock
// Notes:   edges come from flops two and three only
`timescale 1ns/1ps
module sync_edge #(
    parameter int W = 1
) (
    input  wire logic         i_clock,
    input  wire logic         i_rstn,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_lvl,
    output logic      [W-1:0] o_rise,
    output logic      [W-1:0] o_fall
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;
    logic [W-1:0] prev_reg;

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_reg <= '0;
            sync_reg <= '0;
            prev_reg <= '0;
        end else begin
            meta_reg <= i_d;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign o_lvl  = sync_reg;
    assign o_rise = sync_reg & ~prev_reg;
    assign o_fall = ~sync_reg & prev_reg;
endmodule

// *** updown_encoder_counter_channel.sv ***
// Purpose: one 32-bit up/down encoder counter channel with AHB-Lite registers
// Assumes: single 25 MHz clock, pins asynchronous, one master
// Notes:   Overview of operation list below
// Overview of operation
// - external sample clock captures the count on its falling edge
// - control, start and stop inputs act on a software-chosen edge
// - control output is a set level or a match pulse, polarity selectable
// - modes: two-phase sync/async clear, single-phase, gated single-phase
// - two-phase: A leading B counts up, reverse counts down, Z clears
// - single-phase: up adds, down subtracts, both together leave count alone
// - clockwise-decrement setting swaps counting direction
// - gated: count A rises only while B is high
// - x2 and x4 count additional input edges
// - sync clear: A rise while Z active clears, counting resumes afterwards
// - async clear: Z becoming active clears immediately
// - Z polarity positive or negative by software
// - software sets number of Z clears, one after reset
// - software starts and stops one channel or all
// - control input edges start and stop the counter
// - same edge for start and stop toggles the counter
// - control input has exactly one function at a time
// - sampling start and stop also start and stop counting
// - preset loads the preset register into the counter
// - count matching either comparison register can preset
// - preset by software command or control input edge
// - preset and comparison registers are 32 bits
`timescale 1ns/1ps
module updown_encoder_counter_channel
    import updown_counter_pkg::*;
(
    input  wire logic        i_clock,
    input  wire logic        i_rstn,
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic             o_hreadyout,
    output logic             o_hresp,
    output logic      [31:0] o_hrdata,
    input  wire logic        i_phase_a,
    input  wire logic        i_phase_b,
    input  wire logic        i_phase_z,
    input  wire logic        i_channel_control_in,
    input  wire logic        i_external_sample_clock_in,
    input  wire logic        i_external_sampling_start_in,
    input  wire logic        i_external_sampling_stop_in,
    output logic             o_channel_control_out,
    output logic             o_counter_running
);
    logic [IN_W-1:0] lvl, rise, fall;
    ctrl_t           ctrl_reg;
    logic [15:0]     zleft_reg;
    logic [31:0]     preset_reg, cmp0_reg, cmp1_reg, count_reg, sample_reg;
    logic            run_reg, run_next, sampling_reg, zhold_reg, eq0_q, eq1_q;
    logic            wr_pend_reg;
    logic [7:0]      wr_addr_reg;
    logic [4:0]      out_cnt_reg;
    logic            up, dn, inc, dec, x2;
    logic            z_act, z_on, sclr, aclr, clr_ev, pre_ev, zen;
    logic            ctl_ev_start, ctl_ev_stop, samp_go, samp_end;
    logic            eq0, eq1, m0_ev, m1_ev, cmd_wr, addr_ok, sw_start, sw_stop;
    logic [31:0]     rd_mux;

    sync_edge #(.W(IN_W)) u_sync (
        .i_clock (i_clock),
        .i_rstn  (i_rstn),
        .i_d     ({i_external_sampling_stop_in, i_external_sampling_start_in,
                   i_external_sample_clock_in, i_channel_control_in,
                   i_phase_z, i_phase_b, i_phase_a}),
        .o_lvl   (lvl),
        .o_rise  (rise),
        .o_fall  (fall)
    );

    // bus slave: zero wait states, writes land in the data phase
    assign addr_ok = i_hsel && i_hready && i_htrans[1];
    assign cmd_wr  = wr_pend_reg && (wr_addr_reg == ADDR_CMD);

    always_comb begin
        unique case (i_haddr[7:0])
            ADDR_CTRL:   rd_mux = ctrl_reg;
            ADDR_ZCOUNT: rd_mux = {16'h0000, zleft_reg};
            ADDR_PRESET: rd_mux = preset_reg;
            ADDR_CMP0:   rd_mux = cmp0_reg;
            ADDR_CMP1:   rd_mux = cmp1_reg;
            ADDR_COUNT:  rd_mux = count_reg;
            ADDR_STATUS: rd_mux = {26'h000_0000, zen, lvl[IN_CTL], sampling_reg, run_reg, eq1_q, eq0_q};
            ADDR_SAMPLE: rd_mux = sample_reg;
            default:     rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            o_hrdata    <= 32'h0000_0000;
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
        end else begin
            wr_pend_reg <= addr_ok && i_hwrite && (i_haddr[31:8] == 24'h00_0000);
            wr_addr_reg <= i_haddr[7:0];
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
            if (addr_ok && !i_hwrite) begin
                o_hrdata <= (i_haddr[31:8] == 24'h00_0000) ? rd_mux : 32'h0000_0000;
            end
        end
    end

    // config registers; 32-bit preset and compare
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_reg   <= CTRL_RESET;
            preset_reg <= 32'h0000_0000;
            cmp0_reg   <= 32'h0000_0000;
            cmp1_reg   <= 32'h0000_0000;
        end else if (wr_pend_reg) begin
            unique case (wr_addr_reg)
                ADDR_CTRL:   ctrl_reg   <= i_hwdata;
                ADDR_PRESET: preset_reg <= i_hwdata;
                ADDR_CMP0:   cmp0_reg   <= i_hwdata;
                ADDR_CMP1:   cmp1_reg   <= i_hwdata;
                default:     ;
            endcase
        end
    end

    // software commands: one channel here, so "all" aliases this channel
    assign sw_start = cmd_wr && (i_hwdata[CMD_START] || i_hwdata[CMD_START_ALL]);
    assign sw_stop  = cmd_wr && (i_hwdata[CMD_STOP] || i_hwdata[CMD_STOP_ALL]);

    // edge selection
    assign ctl_ev_start = ctrl_reg.ctl_start_fall ? fall[IN_CTL] : rise[IN_CTL];
    assign ctl_ev_stop  = ctrl_reg.ctl_stop_fall ? fall[IN_CTL] : rise[IN_CTL];
    assign samp_go  = (ctrl_reg.samp_start_fall ? fall[IN_XSTART] : rise[IN_XSTART])
                      || (cmd_wr && i_hwdata[CMD_SAMP_GO]);
    assign samp_end = (ctrl_reg.samp_stop_fall ? fall[IN_XSTOP] : rise[IN_XSTOP])
                      || (cmd_wr && i_hwdata[CMD_SAMP_END]);

    // pulse decode
    assign x2 = ctrl_reg.mult != MULT_X1;
    always_comb begin
        up = 1'b0;
        dn = 1'b0;
        unique case (ctrl_reg.mode)
            MODE_2PH_SYNC, MODE_2PH_ASYNC: begin
                up = rise[IN_A] && !lvl[IN_B];
                dn = rise[IN_A] && lvl[IN_B];
                if (x2) begin
                    up = up || (fall[IN_A] && lvl[IN_B]);
                    dn = dn || (fall[IN_A] && !lvl[IN_B]);
                end
                if (ctrl_reg.mult == MULT_X4) begin
                    up = up || (rise[IN_B] && lvl[IN_A]) || (fall[IN_B] && !lvl[IN_A]);
                    dn = dn || (rise[IN_B] && !lvl[IN_A]) || (fall[IN_B] && lvl[IN_A]);
                end
            end
            MODE_SINGLE: begin
                up = rise[IN_A] || (x2 && fall[IN_A]);
                dn = rise[IN_B] || (x2 && fall[IN_B]);
            end
            MODE_GATED: begin
                up = lvl[IN_B] && (rise[IN_A] || (x2 && fall[IN_A]));
            end
        endcase
        inc = ctrl_reg.cw_dec ? dn : up;
        dec = ctrl_reg.cw_dec ? up : dn;
    end

    // phase Z; zero count disables clearing
    assign z_act = lvl[IN_Z] ^ ctrl_reg.z_neg;
    assign z_on  = ctrl_reg.z_neg ? fall[IN_Z] : rise[IN_Z];
    assign zen   = zleft_reg != 16'h0000;
    assign sclr  = (ctrl_reg.mode == MODE_2PH_SYNC) && rise[IN_A] && z_act && (zhold_reg || zen);
    assign aclr  = (ctrl_reg.mode != MODE_2PH_SYNC) && z_on && zen;
    assign clr_ev = sclr || aclr || (cmd_wr && i_hwdata[CMD_CLEAR])
                    || (ctrl_reg.ctl_func == FUNC_CLEAR && ctl_ev_start);

    // one Z period may clear on several A rises but costs one credit
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            zleft_reg <= ZCLR_RESET;
            zhold_reg <= 1'b0;
        end else begin
            zhold_reg <= z_act && (zhold_reg || sclr);
            if (wr_pend_reg && wr_addr_reg == ADDR_ZCOUNT) begin
                zleft_reg <= i_hwdata[15:0];
            end else if (((sclr && !zhold_reg) || aclr) && zleft_reg != ZCLR_UNLIM) begin
                zleft_reg <= zleft_reg - 16'h0001;
            end
        end
    end

    // match events fire only on the cycle equality begins
    assign eq0   = count_reg == cmp0_reg;
    assign eq1   = count_reg == cmp1_reg;
    assign m0_ev = eq0 && !eq0_q;
    assign m1_ev = eq1 && !eq1_q;
    assign pre_ev = (cmd_wr && (i_hwdata[CMD_PRESET] || i_hwdata[CMD_PRE_ALL]))
                    || (ctrl_reg.ctl_func == FUNC_PRESET && ctl_ev_start)
                    || (m0_ev && ctrl_reg.pre_m0) || (m1_ev && ctrl_reg.pre_m1);

    // counter: clear beats preset beats step
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            count_reg <= 32'h0000_0000;
            eq0_q     <= 1'b0;
            eq1_q     <= 1'b0;
        end else begin
            eq0_q <= eq0;
            eq1_q <= eq1;
            if (clr_ev) begin
                count_reg <= 32'h0000_0000;
            end else if (pre_ev) begin
                count_reg <= preset_reg;
            end else if (run_reg && inc && !dec) begin
                count_reg <= count_reg + 32'h0000_0001;
            end else if (run_reg && dec && !inc) begin
                count_reg <= count_reg - 32'h0000_0001;
            end
        end
    end

    // run control; software has the final say in a shared cycle
    always_comb begin
        run_next = run_reg;
        if (ctrl_reg.ctl_func == FUNC_STARTSTOP) begin
            if (ctrl_reg.ctl_start_fall == ctrl_reg.ctl_stop_fall) begin
                if (ctl_ev_start) begin
                    run_next = !run_reg;
                end
            end else begin
                if (ctl_ev_start) begin
                    run_next = 1'b1;
                end
                if (ctl_ev_stop) begin
                    run_next = 1'b0;
                end
            end
        end
        if (ctrl_reg.samp_link && samp_go) begin
            run_next = 1'b1;
        end
        if (ctrl_reg.samp_link && samp_end) begin
            run_next = 1'b0;
        end
        if (sw_start) begin
            run_next = 1'b1;
        end
        if (sw_stop) begin
            run_next = 1'b0;
        end
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            run_reg           <= 1'b0;
            o_counter_running <= 1'b0;
        end else begin
            run_reg           <= run_next;
            o_counter_running <= run_next;
        end
    end

    // sampling window and capture
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            sampling_reg <= 1'b0;
            sample_reg   <= 32'h0000_0000;
        end else begin
            if (samp_end) begin
                sampling_reg <= 1'b0;
            end else if (samp_go) begin
                sampling_reg <= 1'b1;
            end
            if (sampling_reg && fall[IN_XCLK]) begin
                sample_reg <= count_reg;
            end
        end
    end

    // control output; pulse stretched so slow loads can see it
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            out_cnt_reg           <= 5'h00;
            o_channel_control_out <= 1'b0;
        end else begin
            if (m0_ev || m1_ev) begin
                out_cnt_reg <= 5'(OUT_PULSE_CYC);
            end else if (out_cnt_reg != 5'h00) begin
                out_cnt_reg <= out_cnt_reg - 5'h01;
            end
            o_channel_control_out <= ctrl_reg.out_pol ^ (ctrl_reg.out_pulse ?
                (m0_ev || m1_ev || out_cnt_reg != 5'h00) : ctrl_reg.out_level);
        end
    end

    property p_single_cancel;
        @(posedge i_clock) disable iff (!i_rstn)
        (ctrl_reg.mode == MODE_SINGLE && rise[IN_A] && rise[IN_B] && !clr_ev && !pre_ev)
        |=> count_reg == $past(count_reg);
    endproperty
    a_single_cancel: assert property (p_single_cancel) else $error("count moved on simultaneous pulses");

    property p_gate_low;
        @(posedge i_clock) disable iff (!i_rstn)
        (ctrl_reg.mode == MODE_GATED && !lvl[IN_B] && !clr_ev && !pre_ev)
        |=> $stable(count_reg);
    endproperty
    a_gate_low: assert property (p_gate_low) else $error("count moved with gate low");

    property p_preset;
        @(posedge i_clock) disable iff (!i_rstn)
        (pre_ev && !clr_ev) |=> count_reg == $past(preset_reg);
    endproperty
    a_preset: assert property (p_preset) else $error("preset not loaded");

    property p_async_clr;
        @(posedge i_clock) disable iff (!i_rstn)
        (ctrl_reg.mode == MODE_2PH_ASYNC && z_on && zen) |=> count_reg == 32'h0000_0000;
    endproperty
    a_async_clr: assert property (p_async_clr) else $error("async clear missed");

    property p_toggle;
        @(posedge i_clock) disable iff (!i_rstn)
        (ctrl_reg.ctl_func == FUNC_STARTSTOP && !ctrl_reg.ctl_start_fall && !ctrl_reg.ctl_stop_fall
         && rise[IN_CTL] && !sw_start && !sw_stop && !(ctrl_reg.samp_link && (samp_go || samp_end)))
        |=> run_reg != $past(run_reg);
    endproperty
    a_toggle: assert property (p_toggle) else $error("start/stop edge did not toggle");

    property p_match_pulse;
        @(posedge i_clock) disable iff (!i_rstn)
        (ctrl_reg.out_pulse && m0_ev && $stable(ctrl_reg))
        |=> (o_channel_control_out == !ctrl_reg.out_pol)[*8];
    endproperty
    a_match_pulse: assert property (p_match_pulse) else $error("match pulse too short");

    property p_zcount_off;
        @(posedge i_clock) disable iff (!i_rstn)
        (zleft_reg == 16'h0000 && !zhold_reg) |-> !sclr && !aclr;
    endproperty
    a_zcount_off: assert property (p_zcount_off) else $error("Z cleared with no credit");

    property p_x4_b_edge;
        @(posedge i_clock) disable iff (!i_rstn)
        ((ctrl_reg.mode == MODE_2PH_SYNC || ctrl_reg.mode == MODE_2PH_ASYNC) && ctrl_reg.mult == MULT_X4 && run_reg
         && rise[IN_B] && !rise[IN_A] && !fall[IN_A] && !clr_ev && !pre_ev)
        |=> count_reg != $past(count_reg);
    endproperty
    a_x4_b_edge: assert property (p_x4_b_edge) else $error("x4 ignored a B edge");

    property p_sample;
        @(posedge i_clock) disable iff (!i_rstn)
        (sampling_reg && fall[IN_XCLK]) |=> sample_reg == $past(count_reg);
    endproperty
    a_sample: assert property (p_sample) else $error("sample not captured");

    property p_samp_link;
        @(posedge i_clock) disable iff (!i_rstn)
        (ctrl_reg.samp_link && samp_go && !samp_end && !sw_stop) |=> run_reg && sampling_reg;
    endproperty
    a_samp_link: assert property (p_samp_link) else $error("sampling start did not start count");

endmodule

// *** encoder_model.sv ***
// Purpose: behavioural rotary encoder / linear scale on the phase pins
// Assumes: quarter step lasts Q clock periods, pins driven push-pull
// Notes:   motion only on command; no runt pulses are ever produced
`timescale 1ns/1ps
module encoder_model #(
    parameter int Q = 4
) (
    input  wire logic i_clock,
    output logic      o_phase_a,
    output logic      o_phase_b,
    output logic      o_phase_z
);
    initial begin
        o_phase_a = 1'b0;
        o_phase_b = 1'b0;
        o_phase_z = 1'b0;
    end
    // each level held Q periods, well above the synchroniser minimum
    task automatic quarter(input logic a, input logic b);
        @(posedge i_clock);
        o_phase_a <= a;
        o_phase_b <= b;
        repeat (Q - 1) @(posedge i_clock);
    endtask
    // forward: a leads b by a quarter cycle; reverse: b leads a
    task automatic step(input logic fwd, input int n);
        logic [7:0] seq;
        seq = fwd ? 8'b10_11_01_00 : 8'b01_11_10_00;
        repeat (n) begin
            for (int i = 0; i < 4; i++) begin
                quarter(seq[7-2*i], seq[6-2*i]);
            end
        end
        repeat (6) @(posedge i_clock);
    endtask
    task automatic zpulse();
        @(posedge i_clock);
        o_phase_z <= 1'b1;
        repeat (Q) @(posedge i_clock);
        o_phase_z <= 1'b0;
        repeat (Q + 6) @(posedge i_clock);
    endtask
endmodule

// *** updown_encoder_counter_channel_tb_top.sv ***
// Purpose: self-checking bench for the up/down encoder counter channel
// Assumes: one AHB-Lite master, encoder model on the phase pins
// Notes:   reads queue an expectation; a monitor compares in order
`timescale 1ns/1ps
module updown_encoder_counter_channel_tb_top;
    import updown_counter_pkg::*;
    logic        i_clock = 1'b0;
    logic        i_rstn  = 1'b0;
    logic        hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, ctl = 1'b0, xclk = 1'b1, out, run;
    logic [1:0]  htrans = 2'b00;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, p;
    logic        pa, pb, pz, xstart = 1'b0, xstop = 1'b0;
    logic [31:0] exp_q[$], seen_q[$];
    int          n_mismatch = 0, comparisons = 0, seed = 17573, n;
    always #20 i_clock = ~i_clock;
    encoder_model enc_u (.i_clock(i_clock), .o_phase_a(pa), .o_phase_b(pb), .o_phase_z(pz));
    updown_encoder_counter_channel dut_u (
        .i_clock(i_clock), .i_rstn(i_rstn), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(hreadyout),
        .o_hreadyout(hreadyout), .o_hresp(hresp), .o_hrdata(hrdata), .i_phase_a(pa), .i_phase_b(pb),
        .i_phase_z(pz), .i_channel_control_in(ctl), .i_external_sample_clock_in(xclk),
        .i_external_sampling_start_in(xstart), .i_external_sampling_stop_in(xstop),
        .o_channel_control_out(out), .o_counter_running(run));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic observe(input logic [31:0] v, input logic [31:0] e);
        exp_q.push_back(e);
        seen_q.push_back(v);
    endtask
    // address phase held until hready, then data phase until hready again
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr  <= {24'h0000_00, a};
        do @(posedge i_clock); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= d;
        do @(posedge i_clock); while (hreadyout !== 1'b1);
        if (!w) begin
            observe(hrdata, e);
            check({31'h0, hresp}, 32'h0000_0000);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 32'h0000_0000);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0000_0000, e);
    endtask
    task automatic pin_ctl(input logic v);
        @(posedge i_clock);
        ctl <= v;
        repeat (6) @(posedge i_clock);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // queues, not an event: several notes may land in one time step
    always @(negedge i_clock) begin
        while (seen_q.size() != 0) begin
            check(seen_q.pop_front(), exp_q.pop_front());
        end
    end
    initial begin
        repeat (20000) @(posedge i_clock);
        n_mismatch++;
        wrap_up();
    end
    initial begin
        repeat (10) @(posedge i_clock);
        i_rstn <= 1'b1;
        rd(ADDR_CTRL, CTRL_RESET);
        rd(ADDR_ZCOUNT, {16'h0000, ZCLR_RESET});
        wr(8'h40, $random(seed));
        rd(8'h40, 32'h0000_0000);
        observe({31'h0, run}, 32'h0000_0000);
        $display("test reset done");
        wr(ADDR_CMD, 32'h0000_0001);
        for (int m = 0; m < 3; m++) begin
            n = 2 + ($unsigned($random(seed)) % 4);
            wr(ADDR_CTRL, m << 2);
            wr(ADDR_CMD, 32'h0000_0040);
            enc_u.step(1'b1, n);
            rd(ADDR_COUNT, n << m);
            enc_u.step(1'b0, 1);
            rd(ADDR_COUNT, (n - 1) << m);
        end
        $display("test quadrature done");
        wr(ADDR_CTRL, 32'h0000_0001);
        wr(ADDR_CMD, 32'h0000_0040);
        enc_u.step(1'b1, 3);
        enc_u.zpulse();
        rd(ADDR_COUNT, 32'h0000_0000);
        enc_u.step(1'b1, 2);
        enc_u.zpulse();
        rd(ADDR_COUNT, 32'h0000_0002);
        wr(ADDR_ZCOUNT, 32'h0000_FFFF);
        wr(ADDR_CTRL, 32'h0000_0021);
        enc_u.zpulse();
        rd(ADDR_COUNT, 32'h0000_0000);
        rd(ADDR_ZCOUNT, 32'h0000_FFFF);
        enc_u.step(1'b1, 2);
        wr(ADDR_ZCOUNT, 32'h0000_0000);
        enc_u.zpulse();
        rd(ADDR_COUNT, 32'h0000_0002);
        wr(ADDR_ZCOUNT, 32'h0000_0001);
        wr(ADDR_CTRL, 32'h0000_0000);
        // Z high while A rises clears; the next A rise counts again
        fork
            enc_u.step(1'b1, 1);
            enc_u.zpulse();
        join
        enc_u.step(1'b1, 1);
        rd(ADDR_COUNT, 32'h0000_0001);
        $display("test phase z done");
        wr(ADDR_CTRL, 32'h0000_0002);
        wr(ADDR_CMD, 32'h0000_0040);
        for (int k = 0; k < 5; k++) begin
            enc_u.quarter(k < 3 || k == 4, k >= 3);
            enc_u.quarter(1'b0, 1'b0);
        end
        repeat (6) @(posedge i_clock);
        rd(ADDR_COUNT, 32'h0000_0002);
        wr(ADDR_CTRL, 32'h0000_0012);
        enc_u.step(1'b1, 0);
        enc_u.quarter(1'b1, 1'b0);
        enc_u.step(1'b1, 0);
        rd(ADDR_COUNT, 32'h0000_0001);
        wr(ADDR_CTRL, 32'h0000_0003);
        wr(ADDR_CMD, 32'h0000_0040);
        for (int k = 0; k < 4; k++) begin
            enc_u.quarter(1'b0, k < 2);
            enc_u.quarter(1'b1, k < 2);
        end
        enc_u.quarter(1'b0, 1'b0);
        enc_u.step(1'b1, 0);
        rd(ADDR_COUNT, 32'h0000_0002);
        $display("test single phase done");
        p = $random(seed);
        wr(ADDR_CTRL, 32'h0000_0400);
        wr(ADDR_PRESET, p);
        rd(ADDR_PRESET, p);
        wr(ADDR_CMD, 32'h0000_0010);
        rd(ADDR_COUNT, p);
        wr(ADDR_CMP0, 32'h0000_0002);
        wr(ADDR_CMD, 32'h0000_0040);
        enc_u.step(1'b1, 2);
        rd(ADDR_COUNT, p);
        $display("test preset done");
        wr(ADDR_CTRL, 32'h0000_0040);
        wr(ADDR_CMD, 32'h0000_0002);
        @(posedge i_clock);
        observe({31'h0, run}, 32'h0000_0000);
        pin_ctl(1'b1);
        observe({31'h0, run}, 32'h0000_0001);
        pin_ctl(1'b0);
        pin_ctl(1'b1);
        observe({31'h0, run}, 32'h0000_0000);
        wr(ADDR_CTRL, 32'h0000_1000);
        repeat (2) @(posedge i_clock);
        observe({31'h0, out}, 32'h0000_0001);
        wr(ADDR_CTRL, 32'h0000_5000);
        repeat (2) @(posedge i_clock);
        observe({31'h0, out}, 32'h0000_0000);
        wr(ADDR_CTRL, 32'h0000_2000);
        wr(ADDR_CMP0, p);
        repeat (2) @(posedge i_clock);
        observe({31'h0, out}, 32'h0000_0001);
        repeat (30) @(posedge i_clock);
        observe({31'h0, out}, 32'h0000_0000);
        $display("test control pins done");
        wr(ADDR_CTRL, 32'h0000_8000);
        wr(ADDR_CMD, 32'h0000_0040);
        xstart <= 1'b1;
        repeat (6) @(posedge i_clock);
        observe({31'h0, run}, 32'h0000_0001);
        xclk <= 1'b0;
        repeat (8) @(posedge i_clock);
        xclk <= 1'b1;
        enc_u.step(1'b1, 1);
        xclk <= 1'b0;
        repeat (8) @(posedge i_clock);
        rd(ADDR_SAMPLE, 32'h0000_0001);
        xstop <= 1'b1;
        repeat (6) @(posedge i_clock);
        observe({31'h0, run}, 32'h0000_0000);
        $display("test sampling done");
        repeat (2) @(posedge i_clock);
        wrap_up();
    end
endmodule
